/* hw/mc_egress_consts.svh */
`ifndef MC_EGRESS_CONSTS_SVH
`define MC_EGRESS_CONSTS_SVH

// Register byte offsets
`define OFS_CONTROL          12'hE04
`define OFS_UNTRANS_LOW      12'hE20
`define OFS_UNTRANS_HIGH     12'hE24
`define OFS_OVERLAY_LOW      12'hE28
`define OFS_OVERLAY_HIGH     12'hE2C
`define OFS_STATUS           12'hE30
`define OFS_BLOCK_COUNT      12'hE34

// Control word fields
`define CTRL_GROUP_LSB       16
`define CTRL_GROUP_MSB       21
`define CTRL_ENABLE_BIT      31

// Overlay word fields
`define OVL_SIZE_MSB         5
`define OVL_BASE_LSB         6
`define OVL_MIN_LOG2         6'h06

// Reset values
`define RST_WORD             32'h0000_0000

`endif

/* hw/mc_egress_pkg.sv */
package mc_egress_pkg;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // One outgoing multicast packet header
  typedef struct packed {
    logic        untranslated;
    logic [5:0]  group;
    logic [63:0] addr;
  } pkt_hdr_t;

  // Slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

endpackage

/* hw/group_block_filter.sv */
`include "mc_egress_consts.svh"
// Decides whether one packet to one group must be held back
module group_block_filter #(
  parameter int GROUPS = 64
) (
  // Configuration
  input  wire logic [GROUPS-1:0] block_vector,
  input  wire logic [5:0]        group_count,
  input  wire logic              multicast_master_enable,
  // Packet
  input  wire logic              untranslated,
  input  wire logic [5:0]        group,
  // Decision
  output logic                   blocked
);

  // Bits above the configured count never block; disabled multicast blocks nothing
  always_comb begin
    blocked = 1'b0;
    if (multicast_master_enable && untranslated && (group <= group_count)) begin
      blocked = block_vector[group];
    end
  end

endmodule // group_block_filter

/* hw/overlay_rewrite.sv */
`include "mc_egress_consts.svh"
// Replaces the upper address bits of a packet with the overlay base
module overlay_rewrite (
  // Overlay configuration
  input  wire logic [31:0] overlay_low,
  input  wire logic [31:0] overlay_high,
  // Address in and out
  input  wire logic [63:0] addr_in,
  output logic [63:0]      addr_out,
  output logic             active
);

  logic [5:0]  log2_size;
  logic [63:0] base;
  logic [63:0] keep_mask;

  // Window size and base decode
  always_comb begin
    log2_size = overlay_low[`OVL_SIZE_MSB:0];
    base      = {overlay_high, overlay_low[31:`OVL_BASE_LSB], 6'h00};
    active    = (log2_size >= `OVL_MIN_LOG2);
    keep_mask = ~(64'hFFFF_FFFF_FFFF_FFFF << log2_size);
    if (active) begin
      addr_out = (addr_in & keep_mask) | (base & ~keep_mask);
    end else begin
      addr_out = addr_in;
    end
  end

endmodule // overlay_rewrite

/* hw/multicast_egress_block_overlay.sv */
`include "mc_egress_consts.svh"
module multicast_egress_block_overlay #(
  parameter int GROUPS = 64
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // Register bus
  input  wire mc_egress_pkg::wb_req_t wb_req,
  output mc_egress_pkg::wb_rsp_t      wb_rsp,
  // Packet in
  input  wire logic                   in_valid,
  input  wire mc_egress_pkg::pkt_hdr_t in_hdr,
  output logic                        in_ready,
  // Packet out
  output logic                        out_valid,
  output mc_egress_pkg::pkt_hdr_t     out_hdr,
  input  wire logic                   out_ready,
  output logic                        out_dropped
);
  import mc_egress_pkg::*;

  logic        rst_sync1_reg;
  logic        rst_sync2_reg;
  logic        rst_n;
  logic [31:0] control_reg;
  logic [31:0] untrans_low_reg;
  logic [31:0] untrans_high_reg;
  logic [31:0] overlay_low_reg;
  logic [31:0] overlay_high_reg;
  logic [31:0] block_count_reg;
  bus_state_t  bus_state_reg;
  logic        wr_fire;
  logic        blocked;
  logic        ovl_active;
  logic [63:0] new_addr;
  logic [31:0] rd_next;
  logic        out_valid_reg;
  logic        dropped_reg;
  pkt_hdr_t    out_hdr_reg;

  // Merge a write with byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  // Bus slave: ack one cycle after request, dropped next cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (wb_req.cyc && wb_req.stb) begin
            bus_state_reg <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end
  assign wr_fire = (bus_state_reg == BUS_ACK) && wb_req.cyc && wb_req.stb && wb_req.we;

  // Register writes, taken at the acking edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg      <= `RST_WORD;
      untrans_low_reg  <= `RST_WORD;
      untrans_high_reg <= `RST_WORD;
      overlay_low_reg  <= `RST_WORD;
      overlay_high_reg <= `RST_WORD;
    end else if (wr_fire) begin
      unique case (wb_req.adr)
        `OFS_CONTROL: begin
          control_reg <= merge(control_reg, wb_req.dat, wb_req.sel) & 32'h803F_0000;
        end
        `OFS_UNTRANS_LOW: begin
          untrans_low_reg <= merge(untrans_low_reg, wb_req.dat, wb_req.sel);
        end
        `OFS_UNTRANS_HIGH: begin
          untrans_high_reg <= merge(untrans_high_reg, wb_req.dat, wb_req.sel);
        end
        `OFS_OVERLAY_LOW: begin
          overlay_low_reg <= merge(overlay_low_reg, wb_req.dat, wb_req.sel);
        end
        `OFS_OVERLAY_HIGH: begin
          overlay_high_reg <= merge(overlay_high_reg, wb_req.dat, wb_req.sel);
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (wb_req.adr)
      `OFS_CONTROL:      rd_next = control_reg;
      `OFS_UNTRANS_LOW:  rd_next = untrans_low_reg;
      `OFS_UNTRANS_HIGH: rd_next = untrans_high_reg;
      `OFS_OVERLAY_LOW:  rd_next = overlay_low_reg;
      `OFS_OVERLAY_HIGH: rd_next = overlay_high_reg;
      `OFS_STATUS:       rd_next = {30'h0000_0000, ovl_active, out_valid_reg};
      `OFS_BLOCK_COUNT:  rd_next = block_count_reg;
      default:           rd_next = 32'h0000_0000;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= (bus_state_reg == BUS_IDLE) && wb_req.cyc && wb_req.stb;
      wb_rsp.dat <= rd_next;
    end
  end

  // Group filter
  group_block_filter #(
    .GROUPS(GROUPS)
  ) u_filter (
    .block_vector (GROUPS'({untrans_high_reg, untrans_low_reg})),
    .group_count  (control_reg[`CTRL_GROUP_MSB:`CTRL_GROUP_LSB]),
    .multicast_master_enable    (control_reg[`CTRL_ENABLE_BIT]),
    .untranslated (in_hdr.untranslated),
    .group        (in_hdr.group),
    .blocked      (blocked)
  );

  // Overlay address replacement
  overlay_rewrite u_overlay (
    .overlay_low  (overlay_low_reg),
    .overlay_high (overlay_high_reg),
    .addr_in      (in_hdr.addr),
    .addr_out     (new_addr),
    .active       (ovl_active)
  );

  // One-stage output register; stalls when downstream is not ready
  assign in_ready = !out_valid_reg || out_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_hdr_reg   <= '0;
      dropped_reg   <= 1'b0;
    end else begin
      dropped_reg <= 1'b0;
      if (in_ready) begin
        out_valid_reg <= in_valid && !blocked;
        dropped_reg   <= in_valid && blocked;
        if (in_valid && !blocked) begin
          out_hdr_reg.untranslated <= in_hdr.untranslated;
          out_hdr_reg.group        <= in_hdr.group;
          out_hdr_reg.addr         <= new_addr;
        end
      end
    end
  end

  // Count of blocked packets, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      block_count_reg <= `RST_WORD;
    end else if (in_ready && in_valid && blocked && (block_count_reg != 32'hFFFF_FFFF)) begin
      block_count_reg <= block_count_reg + 32'h0000_0001;
    end
  end

  assign out_valid   = out_valid_reg;
  assign out_hdr     = out_hdr_reg;
  assign out_dropped = dropped_reg;

endmodule // multicast_egress_block_overlay

/* bench/mc_egress_chk.sv */
// Protocol checker on the top-level ports
module mc_egress_chk (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    resetn,
  // Register bus
  input wire mc_egress_pkg::wb_req_t  wb_req,
  input wire mc_egress_pkg::wb_rsp_t  wb_rsp,
  // Packet streams
  input wire logic                    in_valid,
  input wire mc_egress_pkg::pkt_hdr_t in_hdr,
  input wire logic                    in_ready,
  input wire logic                    out_valid,
  input wire mc_egress_pkg::pkt_hdr_t out_hdr,
  input wire logic                    out_ready,
  input wire logic                    out_dropped
);
  import mc_egress_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_ack; $rose(wb_req.cyc && wb_req.stb) |=> wb_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_rdy; in_ready == (!out_valid || out_ready); endproperty
  a_rdy: assert property (p_rdy) else $error("bad in_ready");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_hdr); endproperty
  a_hold: assert property (p_hold) else $error("output not held");
  property p_take; in_valid && in_ready |=> out_valid != out_dropped; endproperty
  a_take: assert property (p_take) else $error("packet lost");
  property p_trans; in_valid && in_ready && !in_hdr.untranslated |=> !out_dropped; endproperty
  a_trans: assert property (p_trans) else $error("translated dropped");
  property p_low; in_valid && in_ready |=> !out_valid || out_hdr.addr[5:0] == $past(in_hdr.addr[5:0]);
  endproperty
  a_low: assert property (p_low) else $error("low bits changed");
  property p_drop; out_dropped |-> $past(in_valid && in_ready); endproperty
  a_drop: assert property (p_drop) else $error("spurious drop");
endmodule // mc_egress_chk

bind multicast_egress_block_overlay mc_egress_chk chk (.core_clk, .resetn, .wb_req, .wb_rsp, .in_valid,
  .in_hdr, .in_ready, .out_valid, .out_hdr, .out_ready, .out_dropped);

/* bench/mc_pkt_sink.sv */
// Far-side packet receiver, ready every cycle or every other cycle
module mc_pkt_sink (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Stream
  input  wire logic out_valid,
  output logic      out_ready,
  // Pace select
  input  wire logic slow
);
  // Slow mode toggles ready to stall the block
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) out_ready <= 1'h0;
    else out_ready <= !slow || !out_ready;
  end
endmodule // mc_pkt_sink

/* bench/multicast_egress_block_overlay_tb.sv */
`include "mc_egress_consts.svh"
module multicast_egress_block_overlay_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mc_egress_pkg::*;
  logic        core_clk, resetn, in_valid, in_ready, out_valid, out_ready, out_dropped, slow;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  pkt_hdr_t    in_hdr, out_hdr;
  int          errors, total_checks;
  logic [31:0] rd;
  multicast_egress_block_overlay dut (.core_clk, .resetn, .wb_req, .wb_rsp, .in_valid, .in_hdr,
    .in_ready, .out_valid, .out_hdr, .out_ready, .out_dropped);
  mc_pkt_sink sink (.core_clk, .resetn, .out_valid, .out_ready, .slow);
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 20) begin
      errors++;
      test_done();
    end
  endtask
  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    wb_req <= '{1'h1, 1'h1, we, 4'hF, a, d};
    do begin @(posedge core_clk); n++; end while (wb_rsp.ack !== 1'h1 && n < 20);
    tmo(n);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge core_clk);
  endtask
  // One packet in, then its drop pulse or its output header
  task automatic send(input logic u, input logic [5:0] g, input logic [63:0] a, input logic dr,
                      input logic [63:0] ea);
    int n = 0;
    in_hdr <= '{u, g, a};
    in_valid <= 1'h1;
    do begin @(posedge core_clk); n++; end while (in_ready !== 1'h1 && n < 20);
    tmo(n);
    in_valid <= 1'h0;
    @(posedge core_clk);
    chk(out_dropped, dr);
    n = 0;
    while (!dr && out_valid !== 1'h1 || !dr && out_ready !== 1'h1) begin @(posedge core_clk); n++; tmo(n); end
    if (!dr) chk(out_hdr.addr, ea);
  endtask
  function automatic logic [63:0] ovl(input logic [5:0] s, input logic [63:0] a);
    logic [63:0] m = (64'h1 << s) - 64'h1;
    return (s < 6'h06) ? a : ({32'hCAFE_0001, 32'hDEAD_BE00} & ~m) | (a & m);
  endfunction
  task automatic t_regs();
    logic [11:0] ofs [4] = '{`OFS_UNTRANS_LOW, `OFS_UNTRANS_HIGH, `OFS_OVERLAY_LOW, `OFS_OVERLAY_HIGH};
    foreach (ofs[i]) begin
      wb(1'h0, ofs[i], 32'h0);
      chk(rd, 64'h0);
      wb(1'h1, ofs[i], 32'hA5C3_0F00 + i);
      wb(1'h0, ofs[i], 32'h0);
      chk(rd, 64'hA5C3_0F00 + i);
    end
    wb(1'h1, 12'h100, 32'hFFFF_FFFF);
    wb(1'h0, 12'h100, 32'h0);
    chk(rd, 64'h0);
    $display("regs done");
  endtask
  task automatic t_block();
    wb(1'h1, `OFS_UNTRANS_LOW, 32'h0000_0009);
    wb(1'h1, `OFS_UNTRANS_HIGH, 32'h0000_0100);
    wb(1'h1, `OFS_CONTROL, 32'h8005_0000);
    send(1'h1, 6'h03, 64'h1234, 1'h1, 64'h1234);
    send(1'h0, 6'h03, 64'h1238, 1'h0, 64'h1238);
    send(1'h1, 6'h04, 64'h1240, 1'h0, 64'h1240);
    send(1'h1, 6'h28, 64'h1244, 1'h0, 64'h1244);
    wb(1'h1, `OFS_CONTROL, 32'h803F_0000);
    send(1'h1, 6'h28, 64'h1248, 1'h1, 64'h1248);
    wb(1'h1, `OFS_CONTROL, 32'h8000_0000);
    send(1'h1, 6'h00, 64'h124C, 1'h1, 64'h124C);
    send(1'h1, 6'h03, 64'h1250, 1'h0, 64'h1250);
    wb(1'h1, `OFS_CONTROL, 32'h003F_0000);
    send(1'h1, 6'h03, 64'h1254, 1'h0, 64'h1254);
    $display("block done");
  endtask
  // Overlay sizes around the minimum, far side stalling
  task automatic t_ovl();
    logic [5:0] sz [6] = '{6'h04, 6'h05, 6'h06, 6'h0C, 6'h20, 6'h3F};
    slow <= 1'h1;
    wb(1'h1, `OFS_OVERLAY_HIGH, 32'hCAFE_0001);
    foreach (sz[i]) begin
      wb(1'h1, `OFS_OVERLAY_LOW, 32'hDEAD_BE00 | sz[i]);
      send(1'h0, 6'h07, 64'h0123_4567_89AB_CDEF, 1'h0, ovl(sz[i], 64'h0123_4567_89AB_CDEF));
    end
    slow <= 1'h0;
    $display("overlay done");
  endtask
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    resetn = 1'h0;
    wb_req = '0;
    in_valid = 1'h0;
    in_hdr = '0;
    slow = 1'h0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_block();
    t_ovl();
    test_done();
  end
endmodule // multicast_egress_block_overlay_tb
